// ===== gpx_core.sv
`timescale 1ns/10ps
`default_nettype none
// register core of the 16-bit expander with its serial slave engine
module gpx_core
	import gpx_pkg::*;
#(
	parameter logic [4:0] ADDR_BASE = 5'h10 // fixed upper address bits
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic rst_pin_n, // device reset pin, active low
	input wire logic addr_strap_lo,
	input wire logic addr_strap_hi,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	output logic [31:0] drive_level,
	output logic [15:0] pull_en,
	output logic [15:0] pull_up_sel,
	output logic [1:0] open_drain_sel,
	output logic irq_out,
	output logic irq_oe
);
	// synchronised copies of every outside level
	logic [20:0] sync_s;
	logic rst_pin_s, strap_lo_s, strap_hi_s, scl_s, sda_s;
	logic [15:0] pins_s;
	logic rst_i; // combined core reset

	// all outside levels pass two flops first; idle bus and reset high
	gpx_sync #(.W(21), .RST_VAL(21'h1FFFFF)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.async_in({rst_pin_n, addr_strap_lo, addr_strap_hi, scl_in, sda_in,
			pin_in}),
		.sync_out(sync_s)
	);
	assign {rst_pin_s, strap_lo_s, strap_hi_s, scl_s, sda_s, pins_s} = sync_s;
	// the reset pin holds registers and bus engine while low
	assign rst_i = sys_rst || !rst_pin_s;
	// previous bus levels for edge finding
	logic scl_d_r, sda_d_r;
	always_ff @(posedge clock) begin
		if (rst_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	// data moving while clock is high frames a transfer
	assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
	// bus engine state
	gpx_state_e st_r;
	logic [3:0] bit_cnt_r; // bits seen in current byte
	logic ack_ph_r; // inside the ninth bit
	logic [7:0] sh_r; // receive shifter
	logic [7:0] tx_r; // transmit shifter
	logic rw_r; // direction bit of the address byte
	logic mack_r; // host acknowledged the last read byte
	logic sda_oe_r;
	logic [7:0] ptr_r; // command pointer, never readable
	logic [7:0] rd_data; // byte the pointer selects
	logic addr_hit;
	logic byte_end;
	// four addresses from the straps
	assign addr_hit = (sh_r[7:1] == {ADDR_BASE, strap_hi_s, strap_lo_s});
	assign byte_end = scl_fall && !ack_ph_r && (bit_cnt_r == BITS_PER_BYTE);
	// serial slave: sample on clock rise, change data on clock fall
	always_ff @(posedge clock) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			ack_ph_r <= 1'b0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (start_c) begin
			// a repeated start also lands here
			st_r <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			ack_ph_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (stop_c) begin
			st_r <= ST_IDLE;
			ack_ph_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (scl_rise) begin
			if (ack_ph_r) begin
				// host drives low to ask for another byte
				mack_r <= !sda_s;
			end else if (st_r != ST_IDLE) begin
				if (st_r != ST_RD) begin
					sh_r <= {sh_r[6:0], sda_s};
				end
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end else if (scl_fall) begin
			if (ack_ph_r) begin
				// ninth bit over: release and pick next phase
				ack_ph_r <= 1'b0;
				bit_cnt_r <= 4'h0;
				sda_oe_r <= 1'b0;
				case (st_r)
					ST_ADDR: begin
						if (rw_r) begin
							st_r <= ST_RD;
							tx_r <= rd_data;
							sda_oe_r <= !rd_data[7];
						end else begin
							st_r <= ST_CMD;
						end
					end
					ST_CMD: st_r <= ST_WR;
					ST_RD: begin
						if (mack_r) begin
							tx_r <= rd_data;
							sda_oe_r <= !rd_data[7];
						end else begin
							st_r <= ST_IDLE;
						end
					end
					default: st_r <= st_r;
				endcase
			end else if (bit_cnt_r == BITS_PER_BYTE) begin
				case (st_r)
					ST_ADDR: begin
						if (addr_hit) begin
							ack_ph_r <= 1'b1;
							sda_oe_r <= 1'b1;
							rw_r <= sh_r[RW_BIT];
						end else begin
							// not ours: stay off the bus until next start
							st_r <= ST_IDLE;
						end
					end
					ST_CMD, ST_WR: begin
						ack_ph_r <= 1'b1;
						sda_oe_r <= 1'b1;
					end
					ST_RD: begin
						// release so the host can answer
						ack_ph_r <= 1'b1;
						sda_oe_r <= 1'b0;
					end
					default: st_r <= ST_IDLE;
				endcase
			end else if (st_r == ST_RD) begin
				tx_r <= {tx_r[6:0], 1'b0};
				sda_oe_r <= !tx_r[6];
			end
		end
	end
	// open-drain data: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_r;
	// one-cycle events of the engine
	logic cmd_done, wr_done, rd_ack;
	assign cmd_done = byte_end && (st_r == ST_CMD);
	assign wr_done = byte_end && (st_r == ST_WR);
	// rising clock of the ninth bit of a read byte
	assign rd_ack = scl_rise && ack_ph_r && (st_r == ST_RD);
	// pointer: loaded by the command byte, steps within its pair
	always_ff @(posedge clock) begin
		if (rst_i) begin
			ptr_r <= 8'h00;
		end else if (cmd_done) begin
			ptr_r <= sh_r;
		end else if (wr_done || rd_ack) begin
			ptr_r <= {ptr_r[7:1], !ptr_r[0]};
		end
	end
	// host-visible registers
	logic [15:0] out_r, pol_r, dir_r, cap_r, pue_r, pus_r, blk_r;
	logic [31:0] drv_r;
	logic [1:0] ods_r;
	// writes land on the pointed register; unlisted and read-only ignored
	always_ff @(posedge clock) begin
		if (rst_i) begin
			out_r <= {RST_ONES, RST_ONES};
			pol_r <= {RST_ZERO, RST_ZERO};
			dir_r <= {RST_ONES, RST_ONES};
			drv_r <= {RST_ONES, RST_ONES, RST_ONES, RST_ONES};
			cap_r <= {RST_ZERO, RST_ZERO};
			pue_r <= {RST_ZERO, RST_ZERO};
			pus_r <= {RST_ONES, RST_ONES};
			blk_r <= {RST_ONES, RST_ONES};
			ods_r <= RST_ZERO[1:0];
		end else if (wr_done) begin
			case (ptr_r)
				REG_OUT0: out_r[7:0] <= sh_r;
				REG_OUT1: out_r[15:8] <= sh_r;
				REG_POL0: pol_r[7:0] <= sh_r;
				REG_POL1: pol_r[15:8] <= sh_r;
				REG_DIR0: dir_r[7:0] <= sh_r;
				REG_DIR1: dir_r[15:8] <= sh_r;
				REG_DRV0L: drv_r[7:0] <= sh_r;
				REG_DRV0H: drv_r[15:8] <= sh_r;
				REG_DRV1L: drv_r[23:16] <= sh_r;
				REG_DRV1H: drv_r[31:24] <= sh_r;
				REG_CAP0: cap_r[7:0] <= sh_r;
				REG_CAP1: cap_r[15:8] <= sh_r;
				REG_PUE0: pue_r[7:0] <= sh_r;
				REG_PUE1: pue_r[15:8] <= sh_r;
				REG_PUS0: pus_r[7:0] <= sh_r;
				REG_PUS1: pus_r[15:8] <= sh_r;
				REG_BLK0: blk_r[7:0] <= sh_r;
				REG_BLK1: blk_r[15:8] <= sh_r;
				REG_ODS: ods_r <= sh_r[1:0];
				// input levels, sources and unlisted codes drop the byte
				default: ods_r <= ods_r;
			endcase
		end
	end
	// per-pin detectors
	logic [15:0] cell_val, pend;
	logic [1:0] port_clr;
	assign port_clr[0] = rd_ack && (ptr_r == REG_IN0);
	assign port_clr[1] = rd_ack && (ptr_r == REG_IN1);

	for (genvar i = 0; i < 16; i++) begin : g_pin
		gpx_pin_cell u_cell (
			.clock(clock),
			.rst(rst_i),
			.lvl(pins_s[i]),
			.is_input(dir_r[i]),
			.cap_en(cap_r[i]),
			.rd_clr(port_clr[i / 8]),
			.value(cell_val[i]),
			.pend(pend[i])
		);
	end

	logic [15:0] in_view, src;
	assign in_view = cell_val ^ pol_r;
	assign src = pend & ~blk_r;

	// read mux; bit 6 picks the extended bank
	always_comb begin
		rd_data = 8'h00;
		if (ptr_r[EXT_BIT]) begin
			case (ptr_r)
				REG_DRV0L: rd_data = drv_r[7:0];
				REG_DRV0H: rd_data = drv_r[15:8];
				REG_DRV1L: rd_data = drv_r[23:16];
				REG_DRV1H: rd_data = drv_r[31:24];
				REG_CAP0: rd_data = cap_r[7:0];
				REG_CAP1: rd_data = cap_r[15:8];
				REG_PUE0: rd_data = pue_r[7:0];
				REG_PUE1: rd_data = pue_r[15:8];
				REG_PUS0: rd_data = pus_r[7:0];
				REG_PUS1: rd_data = pus_r[15:8];
				REG_BLK0: rd_data = blk_r[7:0];
				REG_BLK1: rd_data = blk_r[15:8];
				REG_SRC0: rd_data = src[7:0];
				REG_SRC1: rd_data = src[15:8];
				REG_ODS: rd_data = {6'h00, ods_r};
				default: rd_data = 8'h00;
			endcase
		end else begin
			case (ptr_r)
				REG_IN0: rd_data = in_view[7:0];
				REG_IN1: rd_data = in_view[15:8];
				REG_OUT0: rd_data = out_r[7:0];
				REG_OUT1: rd_data = out_r[15:8];
				REG_POL0: rd_data = pol_r[7:0];
				REG_POL1: rd_data = pol_r[15:8];
				REG_DIR0: rd_data = dir_r[7:0];
				REG_DIR1: rd_data = dir_r[15:8];
				default: rd_data = 8'h00;
			endcase
		end
	end

	// pin drivers; open-drain ports release instead of driving high
	logic [15:0] od_mask;
	assign od_mask = {{8{ods_r[1]}}, {8{ods_r[0]}}};
	always_ff @(posedge clock) begin
		if (rst_i) begin
			pin_out <= {RST_ONES, RST_ONES};
			pin_oe <= 16'h0000;
		end else begin
			pin_out <= out_r;
			pin_oe <= ~dir_r & ~(od_mask & out_r);
		end
	end

	// configuration straight to the pad cells
	assign drive_level = drv_r;
	// pulls drop out while a port is open-drain
	assign pull_en = pue_r & ~od_mask;
	assign pull_up_sel = pus_r;
	assign open_drain_sel = ods_r;
	// interrupt line, registered, low when active
	logic irq_r;
	always_ff @(posedge clock) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |src;
		end
	end
	assign irq_out = 1'b0;
	assign irq_oe = irq_r;
	property p_reset_defaults;
		@(posedge clock) rst_i |=> (out_r == 16'hFFFF) && (dir_r == 16'hFFFF)
			&& (pol_r == 16'h0000) && (blk_r == 16'hFFFF);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("bad reset defaults");
	property p_src_zero;
		@(posedge clock) rst_i |=> (src == 16'h0000) && !irq_oe;
	endproperty
	a_src_zero: assert property (p_src_zero)
		else $error("interrupt source not clear after reset");
	property p_irq_follow;
		@(posedge clock) disable iff (rst_i)
		##1 irq_oe == (|($past(pend) & ~$past(blk_r)));
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("interrupt line does not follow unblocked sources");
	property p_ptr_load;
		@(posedge clock) disable iff (rst_i)
		cmd_done |=> ptr_r == $past(sh_r);
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("command byte not loaded into pointer");
	property p_unlisted_write;
		@(posedge clock) disable iff (rst_i)
		wr_done && !ptr_r[EXT_BIT] && (ptr_r[7:3] != 5'h00) |=>
			$stable(out_r) && $stable(dir_r) && $stable(pol_r);
	endproperty
	a_unlisted_write: assert property (p_unlisted_write)
		else $error("unlisted code changed a register");
	property p_drive_only_out;
		@(posedge clock) disable iff (rst_i)
		##1 (pin_oe & $past(dir_r)) == 16'h0000;
	endproperty
	a_drive_only_out: assert property (p_drive_only_out)
		else $error("input pin being driven");
	property p_read_dir;
		@(posedge clock) disable iff (rst_i)
		scl_fall && ack_ph_r && (st_r == ST_ADDR) |=>
			(st_r == (rw_r ? ST_RD : ST_CMD));
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("wrong transfer direction after address");
	property p_addr_ack;
		@(posedge clock) disable iff (rst_i)
		byte_end && (st_r == ST_ADDR) && !start_c && !stop_c |=>
			ack_ph_r == $past(addr_hit);
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("address acknowledge mismatch with straps");
endmodule
`default_nettype wire

// ===== gpx_pkg.sv
// Functional notes
// - two strap pins pick one of four addresses
// - address byte last bit: one read, zero write
// - byte after address is write-only command pointer
// - bit 6 selects extended register bank
// - reset loads documented ones and zeros defaults
// - interrupt source pair is read-only, zero after reset
// - input level shows pin, writes ignored
// - output value drives outputs only, reads stored
// - polarity bit one inverts input level view
// - direction one is input, zero drives pin
// - two-bit drive level, quarter steps to full
// - drive fields four per byte, low pin low
// - capture enable acts only on input pins
// - unlatched change interrupts; read or revert clears
// - latched change holds value and interrupt through revert
// - read after latched read returns live level
// - mixed latched and unlatched revert keeps interrupt
// - latched to unlatched switch keeps pending interrupt
// - after switch, reads follow live or held level
// - block bit one suppresses interrupt for pin
// - output pins never raise an interrupt
// - port read clears interrupt at acknowledge bit
// - low reset pin holds registers and bus engine
`default_nettype none
package gpx_pkg;
	// register command codes
	localparam logic [7:0] REG_IN0 = 8'h00;
	localparam logic [7:0] REG_IN1 = 8'h01;
	localparam logic [7:0] REG_OUT0 = 8'h02;
	localparam logic [7:0] REG_OUT1 = 8'h03;
	localparam logic [7:0] REG_POL0 = 8'h04;
	localparam logic [7:0] REG_POL1 = 8'h05;
	localparam logic [7:0] REG_DIR0 = 8'h06;
	localparam logic [7:0] REG_DIR1 = 8'h07;
	localparam logic [7:0] REG_DRV0L = 8'h40;
	localparam logic [7:0] REG_DRV0H = 8'h41;
	localparam logic [7:0] REG_DRV1L = 8'h42;
	localparam logic [7:0] REG_DRV1H = 8'h43;
	localparam logic [7:0] REG_CAP0 = 8'h44;
	localparam logic [7:0] REG_CAP1 = 8'h45;
	localparam logic [7:0] REG_PUE0 = 8'h46;
	localparam logic [7:0] REG_PUE1 = 8'h47;
	localparam logic [7:0] REG_PUS0 = 8'h48;
	localparam logic [7:0] REG_PUS1 = 8'h49;
	localparam logic [7:0] REG_BLK0 = 8'h4A;
	localparam logic [7:0] REG_BLK1 = 8'h4B;
	localparam logic [7:0] REG_SRC0 = 8'h4C;
	localparam logic [7:0] REG_SRC1 = 8'h4D;
	localparam logic [7:0] REG_ODS = 8'h4F;
	// field positions
	localparam int EXT_BIT = 6;
	localparam int RW_BIT = 0;
	// reset values
	localparam logic [7:0] RST_ONES = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// serial framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// drive level encodings, in quarters of full drive
	localparam logic [1:0] DRV_QUARTER = 2'h0;
	localparam logic [1:0] DRV_FULL = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_RD
	} gpx_state_e;
endpackage
`default_nettype wire

// ===== gpx_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for a bundle of asynchronous levels
module gpx_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r; // first stage, read only by second stage

	// plain double flop; no logic looks at the first stage
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== gpx_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none
// per-pin change detector, capture latch and pending flag
module gpx_pin_cell (
	input wire logic clock,
	input wire logic rst,
	input wire logic lvl, // synchronised pin level
	input wire logic is_input, // direction bit, one means input
	input wire logic cap_en, // capture enable bit
	input wire logic rd_clr, // read of this pin's port acknowledged
	output logic value, // level shown in input register, true polarity
	output logic pend // interrupt pending for this pin
);
	logic ref_r; // level the host last saw
	logic held_r; // captured level
	logic held_v_r; // capture holds a value
	logic change; // live level differs from last seen
	logic capture;

	assign change = is_input && (lvl != ref_r);
	assign capture = change && cap_en && !held_v_r;

	// reference moves to the live level on every acknowledged read
	always_ff @(posedge clock) begin
		if (rst) begin
			ref_r <= 1'b0;
		end else if (rd_clr) begin
			ref_r <= lvl;
		end
	end

	// capture latch; a read releases it; mode switch leaves it alone
	// a capture landing in the cycle of a read wins, so no change is lost
	always_ff @(posedge clock) begin
		if (rst) begin
			held_r <= 1'b0;
			held_v_r <= 1'b0;
		end else if (capture) begin
			held_r <= lvl;
			held_v_r <= 1'b1;
		end else if (rd_clr) begin
			held_v_r <= 1'b0;
		end
	end

	// held level only while capture is enabled; live level otherwise
	assign value = (cap_en && held_v_r) ? held_r : lvl;
	// unlatched revert clears by itself; held capture persists
	assign pend = held_v_r || (change && !cap_en);

	property p_hold_persists;
		@(posedge clock) disable iff (rst)
		held_v_r && !rd_clr |=> held_v_r;
	endproperty
	a_hold_persists: assert property (p_hold_persists)
		else $error("captured level dropped without a read");

	property p_out_quiet;
		@(posedge clock) disable iff (rst)
		!is_input && !held_v_r |-> !pend;
	endproperty
	a_out_quiet: assert property (p_out_quiet)
		else $error("output pin raised pending");
endmodule
`default_nettype wire

// ===== gpx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// serial bus host model: makes the bus clock and pulls the data wire low
module gpx_host_model (
	input wire logic clock, // core clock, paces the bus phases
	input wire logic sda_line, // resolved data wire, pulled up
	input wire logic [6:0] dev_addr, // target address to call
	output logic scl, // bus clock, stands high between frames
	output logic sda_low // high pulls the data wire low
);
	logic acks_ok; // device acknowledged every byte it received in the last transfer
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		acks_ok = 1'b0;
	end
	// wait whole core clocks, so every change lands just after an edge
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one bit: data set in low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		wt(4);
		scl <= 1'b1;
		wt(4);
		r = sda_line;
		wt(4);
		scl <= 1'b0;
		wt(4);
	endtask
	// start or repeated start: data falls while clock high
	task automatic bus_start();
		sda_low <= 1'b0;
		wt(4);
		scl <= 1'b1;
		wt(8);
		sda_low <= 1'b1;
		wt(8);
		scl <= 1'b0;
		wt(4);
	endtask
	// stop: data rises while clock high, clock then rests high
	task automatic bus_stop();
		sda_low <= 1'b1;
		wt(4);
		scl <= 1'b1;
		wt(8);
		sda_low <= 1'b0;
		wt(8);
	endtask
	// eight bits msb first, then the ninth bit; ack true when line low
	task automatic byte_io(input logic [7:0] tx, input logic a_in,
		output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(a_in, r);
		ack = ~r;
	endtask
	// register write: address with write bit, command byte, one data byte
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		logic [7:0] rx;
		logic a0, a1, a2;
		bus_start();
		byte_io({dev_addr, 1'b0}, 1'b1, rx, a0);
		byte_io(cmd, 1'b1, rx, a1);
		byte_io(d, 1'b1, rx, a2);
		bus_stop();
		acks_ok = a0 & a1 & a2;
	endtask
	// pair read: set pointer, repeated start, ack first byte, nack second
	task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
		logic [7:0] rx;
		logic a0, a1, a2, x;
		bus_start();
		byte_io({dev_addr, 1'b0}, 1'b1, rx, a0);
		byte_io(cmd, 1'b1, rx, a1);
		bus_start();
		byte_io({dev_addr, 1'b1}, 1'b1, rx, a2);
		byte_io(8'hFF, 1'b0, d[7:0], x);
		byte_io(8'hFF, 1'b1, d[15:8], x);
		bus_stop();
		acks_ok = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
// bench for the expander core with a host model on the serial side
module tb;
	import gpx_pkg::*;
	localparam logic [4:0] BASE = 5'h10; // fixed upper address bits
	logic clock, sys_rst, rst_pin_n; // core clock and both resets
	logic strap_lo, strap_hi; // address straps
	logic scl, sda_low, sda_line; // serial wires
	logic sda_out, sda_oe, irq_out, irq_oe; // open-drain outputs
	logic [6:0] dev_addr; // address the host calls
	logic [15:0] ext_lvl, pin_in, pin_out, pin_oe, pull_en, pull_up_sel;
	logic [31:0] drive_level; // two bits per pin
	logic [1:0] open_drain_sel; // per-port output stage
	logic [15:0] rv; // last pair read
	int fails, check_count; // mismatches and comparisons
	// even codes read as pairs, with their reset values
	logic [7:0] dcode [11] = '{8'h02, 8'h04, 8'h06, 8'h40, 8'h42, 8'h44,
		8'h46, 8'h48, 8'h4A, 8'h4C, 8'h4E};
	logic [15:0] dval [11] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
	// pads: driven pins show the driven value, inputs the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	// data wire is pulled up; either party may pull it low
	assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	gpx_core #(.ADDR_BASE(BASE)) gpx_core_i (.clock(clock),
		.sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .addr_strap_lo(strap_lo),
		.addr_strap_hi(strap_hi), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .drive_level(drive_level),
		.pull_en(pull_en), .pull_up_sel(pull_up_sel),
		.open_drain_sel(open_drain_sel), .irq_out(irq_out), .irq_oe(irq_oe));
	gpx_host_model gpx_host_model_i (.clock(clock), .sda_line(sda_line),
		.dev_addr(dev_addr), .scl(scl), .sda_low(sda_low));
	// 100 MHz core clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// compare and count; four-state equality so unknowns never match
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// long enough for the interrupt path to settle through the synchroniser
	task automatic irq_is(input logic exp);
		wt(20);
		chk(irq_oe, exp);
	endtask
	task automatic rdc(input logic [7:0] cmd, input logic [15:0] exp);
		gpx_host_model_i.rd(cmd, rv);
		chk(rv, exp);
	endtask
	task automatic conclude();
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under this span
	initial begin
		#900000;
		fails++;
		conclude();
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		rst_pin_n = 1'b1;
		strap_lo = 1'b0;
		strap_hi = 1'b0;
		ext_lvl = 16'h3C00;
		dev_addr = {BASE, 2'b00};
		fails = 0;
		check_count = 0;
		wt(4);
		sys_rst <= 1'b0;
		wt(8);
		chk({pin_oe, pin_out}, 32'h0000FFFF);
		chk(drive_level, 32'hFFFFFFFF);
		chk({pull_en, pull_up_sel}, 32'h0000FFFF);
		chk({open_drain_sel, irq_oe, irq_out, sda_out}, 32'h0);
		for (int i = 0; i < 11; i++)
			rdc(dcode[i], dval[i]);
		rdc(8'h00, 16'h3C00);
		// writes to read-only and unlisted places are dropped
		gpx_host_model_i.wr(8'h00, 8'hFF);
		gpx_host_model_i.wr(8'h4C, 8'hFF);
		gpx_host_model_i.wr(8'h4E, 8'hFF);
		rdc(8'h00, 16'h3C00);
		rdc(8'h4C, 16'h0000);
		rdc(8'h4E, 16'h0000);
		// pins 4..7 become outputs
		gpx_host_model_i.wr(8'h02, 8'hA5);
		gpx_host_model_i.wr(8'h06, 8'h0F);
		wt(4);
		chk({pin_oe[7:0], pin_out[7:0]}, 32'hF0A5);
		// a low-bank code outside the list must not alias onto 02h
		gpx_host_model_i.wr(8'h12, 8'h00);
		rdc(8'h12, 16'h0000);
		rdc(8'h02, 16'hFFA5);
		rdc(8'h00, 16'h3CA0);
		gpx_host_model_i.wr(8'h41, 8'h1B);
		gpx_host_model_i.wr(8'h40, 8'h00);
		gpx_host_model_i.wr(8'h42, 8'h5A);
		chk(drive_level[23:0], 32'h5A1B00);
		// open-drain port 0 releases the pins that should go high
		gpx_host_model_i.wr(8'h4F, 8'h01);
		chk({open_drain_sel, pin_oe[7:0]}, 32'h150);
		gpx_host_model_i.wr(8'h4F, 8'h00);
		rdc(8'h40, 16'h1B00);
		gpx_host_model_i.wr(8'h05, 8'h0F);
		rdc(8'h00, 16'h33A0);
		// unmask all of port 0 but pin 1
		gpx_host_model_i.wr(8'h4A, 8'h02);
		irq_is(1'b0);
		ext_lvl[0] <= 1'b1;
		irq_is(1'b1);
		ext_lvl[0] <= 1'b0;
		irq_is(1'b0);
		ext_lvl[0] <= 1'b1;
		irq_is(1'b1);
		rdc(8'h00, 16'h33A1);
		irq_is(1'b0);
		ext_lvl[1] <= 1'b1;
		irq_is(1'b0);
		// latch enabled on an output pin must stay without effect
		gpx_host_model_i.wr(8'h44, 8'h80);
		gpx_host_model_i.wr(8'h02, 8'h25);
		gpx_host_model_i.wr(8'h02, 8'hA5);
		irq_is(1'b0);
		rdc(8'h00, 16'h33A3);
		// pin 0 latched: change and revert before the read
		gpx_host_model_i.wr(8'h44, 8'h01);
		ext_lvl[0] <= 1'b0;
		irq_is(1'b1);
		ext_lvl[0] <= 1'b1;
		irq_is(1'b1);
		rdc(8'h00, 16'h33A2);
		irq_is(1'b0);
		rdc(8'h00, 16'h33A3);
		// latched pin 0 and unlatched pin 2 toggle together, then revert
		ext_lvl[2:0] <= 3'b110;
		wt(20);
		ext_lvl[2:0] <= 3'b011;
		irq_is(1'b1);
		rdc(8'h00, 16'h33A2);
		irq_is(1'b0);
		rdc(8'h00, 16'h33A3);
		// latched to unlatched with an interrupt pending
		ext_lvl[0] <= 1'b0;
		wt(20);
		ext_lvl[0] <= 1'b1;
		gpx_host_model_i.wr(8'h44, 8'h00);
		irq_is(1'b1);
		rdc(8'h00, 16'h33A3);
		// unlatched to latched while the pin differs
		ext_lvl[0] <= 1'b0;
		irq_is(1'b1);
		gpx_host_model_i.wr(8'h44, 8'h01);
		ext_lvl[0] <= 1'b1;
		wt(20);
		rdc(8'h00, 16'h33A2);
		// each strap setting answers its own address and not the complemented one
		for (int s = 0; s < 4; s++) begin
			{strap_hi, strap_lo} <= s[1:0];
			dev_addr <= {BASE, s[1:0]};
			wt(8);
			gpx_host_model_i.wr(8'h03, 8'(s));
			chk(gpx_host_model_i.acks_ok, 1'b1);
			dev_addr <= {BASE, ~s[1:0]};
			wt(2);
			gpx_host_model_i.wr(8'h03, 8'hEE);
			chk(gpx_host_model_i.acks_ok, 1'b0);
		end
		dev_addr <= {BASE, 2'b11};
		rdc(8'h02, 16'h03A5);
		// a pending latched interrupt must not survive the reset pin
		ext_lvl[0] <= 1'b0;
		irq_is(1'b1);
		// reset pin returns every register to its default
		rst_pin_n <= 1'b0;
		wt(10);
		chk({pin_oe, pin_out}, 32'h0000FFFF);
		chk(irq_oe, 1'b0);
		rst_pin_n <= 1'b1;
		wt(10);
		rdc(8'h02, 16'hFFFF);
		rdc(8'h44, 16'h0000);
		rdc(8'h00, 16'h3C02);
		conclude();
	end
endmodule
`default_nettype wire
